// File: rtl/ips_pkg.sv
// Shared constants for the interrupt priority and external trigger block
package ips_pkg;

    // Register indices; byte address on the bus is four times the index
    localparam logic [7:0] IDX_TMR_EXT   = 8'h88;
    localparam logic [7:0] IDX_PRIO_HI_B = 8'hB7;
    localparam logic [7:0] IDX_PRIO_LO_B = 8'hB8;
    localparam logic [7:0] IDX_PRIO_LO_E = 8'hEF;
    localparam logic [7:0] IDX_PRIO_HI_E = 8'hF7;
    localparam logic [7:0] IDX_PRIO_LO_2 = 8'hFE;
    localparam logic [7:0] IDX_PRIO_HI_2 = 8'hFF;
    localparam logic [7:0] IDX_CTRL      = 8'h40;
    localparam logic [7:0] IDX_SRC_EN    = 8'h41;
    localparam logic [7:0] IDX_EVT_STAT  = 8'h42;
    localparam logic [7:0] IDX_EVT_CLR   = 8'h43;
    localparam logic [7:0] IDX_EVT_EN    = 8'h44;

    // Control register field layout
    localparam int TEC_TYPE0_BIT  = 0;
    localparam int TEC_FLAG0_BIT  = 1;
    localparam int TEC_TYPE1_BIT  = 2;
    localparam int TEC_FLAG1_BIT  = 3;
    localparam int TEC_STRIDE     = 2;
    localparam int CTRL_GATE_BIT  = 0;

    // Trigger type encodings
    localparam logic TRIG_LEVEL = 1'b0;
    localparam logic TRIG_FALL  = 1'b1;

    // Priority register widths; sources are packed base, ext, ext2
    localparam int BASE_W = 7;
    localparam int EXT_W  = 8;
    localparam int EXT2_W = 3;
    localparam int NSRC   = BASE_W + EXT_W + EXT2_W;
    localparam int SRC_W  = 5;
    localparam int NEXT   = 2;

    // Source indices of the two external inputs in the packed vector
    localparam logic [SRC_W-1:0] SRC_EXT0 = 5'h00;
    localparam logic [SRC_W-1:0] SRC_EXT1 = 5'h02;

    // Reset values
    localparam logic [7:0]  RST_REG8  = 8'h00;
    localparam logic [NEXT-1:0] RST_PINS = 2'h3;

endpackage

// File: rtl/ips_arbiter.sv
// Highest priority level selector with fixed index tie break
`timescale 1ns/1ps
module ips_arbiter #(
    parameter int N  = 18,
    parameter int IW = 5
) (
    input  wire logic [N-1:0]   req_i,
    input  wire logic [2*N-1:0] lvl_i,
    output logic                any_o,
    output logic [IW-1:0]       idx_o,
    output logic [1:0]          lvl_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Scan from the top index down; ">=" lets the lower index win a tie
    always_comb begin
        any_o = 1'b0;
        idx_o = '0;
        lvl_o = 2'h0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req_i[i] && (!any_o || lvl_i[2*i+:2] >= lvl_o)) begin
                any_o = 1'b1;
                idx_o = IW'(i);
                lvl_o = lvl_i[2*i+:2];
            end
        end
    end

endmodule

// File: rtl/ips_ctrl.sv
// Interrupt priority registers, external trigger flags and request selection
//
// Contract
// - Level is high bit joined with low bit
// - Base low register: ADC down to ext0
// - Base high register mirrors base low layout
// - Extended low: timer2 down to two-wire
// - Extended high mirrors extended low layout
// - Second low: wake, timer3, uart1 bits
// - Second high: wake, timer3, uart1 bits
// - Type 0 is low level, 1 falling
// - Edge flag sticky until software or service
// - Level mode flag is inverted pin
// - Level mode flag ignores software writes
// - Control bits 3,2 input1; 1,0 input0
// - Pins sampled each clock, high-low edge
// - Global gate blocks every request on irq_req_o; evt_irq_o is not gated
`timescale 1ns/1ps
module ips_ctrl
    import ips_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [9:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    input  wire logic              ext_pin0_n_i,
    input  wire logic              ext_pin1_n_i,
    input  wire logic [NSRC-1:0]   periph_req_i,
    input  wire logic              svc_ack_i,
    input  wire logic [SRC_W-1:0]  svc_src_i,
    output logic                   irq_req_o,
    output logic      [SRC_W-1:0]  irq_src_o,
    output logic      [1:0]        irq_level_o,
    output logic                   evt_irq_o
);

    ////////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic              ack;
        logic [31:0]       rdat;
        logic [NEXT-1:0]   trig_type;
        logic [NEXT-1:0]   req_flag;
        logic [NEXT-1:0]   pin_prev;
        logic [BASE_W-1:0] prio_lo_b;
        logic [BASE_W-1:0] prio_hi_b;
        logic [EXT_W-1:0]  prio_lo_e;
        logic [EXT_W-1:0]  prio_hi_e;
        logic [EXT2_W-1:0] prio_lo_2;
        logic [EXT2_W-1:0] prio_hi_2;
        logic              global_irq_gate;
        logic [NSRC-1:0]   src_en;
        logic [NEXT-1:0]   evt_status;
        logic [NEXT-1:0]   evt_enable;
        logic              req_valid;
        logic [SRC_W-1:0]  req_src;
        logic [1:0]        req_level;
    } ips_state_t;

    ips_state_t        st;
    ips_state_t        next_st;
    logic [NEXT-1:0]   pins;
    logic [NEXT-1:0]   fall;
    logic [NEXT-1:0]   hw_clr;
    logic [NSRC-1:0]   lo_vec;
    logic [NSRC-1:0]   hi_vec;
    logic [NSRC-1:0]   req_vec;
    logic [2*NSRC-1:0] lvl_vec;
    logic              arb_any;
    logic [SRC_W-1:0]  arb_idx;
    logic [1:0]        arb_lvl;
    logic              bus_hit;
    logic              bus_wr;
    logic              wr_tec;
    logic [7:0]        idx;

    // Merge only the enabled byte lanes of a write
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b+:8] = new_v[8*b+:8];
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin sampling and service-entry clears
    assign pins = {ext_pin1_n_i, ext_pin0_n_i};
    assign fall = st.pin_prev & ~pins;
    assign hw_clr[0] = svc_ack_i && (svc_src_i == SRC_EXT0);
    assign hw_clr[1] = svc_ack_i && (svc_src_i == SRC_EXT1);

    // Packed priority bits, one entry per source in natural order
    assign lo_vec = {st.prio_lo_2, st.prio_lo_e, st.prio_lo_b};
    assign hi_vec = {st.prio_hi_2, st.prio_hi_e, st.prio_hi_b};

    ////////////////////////////////////////////////////////////////////////////
    // Per-source level and pending request
    genvar g;
    generate
        for (g = 0; g < NSRC; g++) begin : g_src
            logic pend;
            assign lvl_vec[2*g+:2] = {hi_vec[g], lo_vec[g]};
            if (g == int'(SRC_EXT0)) begin : g_e0
                assign pend = st.req_flag[0];
            end else if (g == int'(SRC_EXT1)) begin : g_e1
                assign pend = st.req_flag[1];
            end else begin : g_pr
                assign pend = periph_req_i[g];
            end
            assign req_vec[g] = pend & st.src_en[g];
        end
    endgenerate

    ips_arbiter #(
        .N  (NSRC),
        .IW (SRC_W)
    ) u_arb (
        .req_i (req_vec),
        .lvl_i (lvl_vec),
        .any_o (arb_any),
        .idx_o (arb_idx),
        .lvl_o (arb_lvl)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode; writes land on the edge where ack is already high
    assign bus_hit = wb_cyc_i & wb_stb_i;
    assign bus_wr  = bus_hit & wb_we_i & st.ack;
    assign idx     = wb_adr_i[9:2];
    assign wr_tec  = bus_wr && wb_sel_i[0] && (idx == IDX_TMR_EXT);

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        logic [31:0] rd;
        logic [31:0] wv;
        rd = 32'h0000_0000;
        wv = 32'h0000_0000;
        next_st = st;

        // One wait state, then ack for one cycle
        next_st.ack = bus_hit & ~st.ack;

        // Read mux; unmapped indices and the clear register read zero
        if (idx == IDX_TMR_EXT) begin
            rd[TEC_TYPE0_BIT] = st.trig_type[0];
            rd[TEC_FLAG0_BIT] = st.req_flag[0];
            rd[TEC_TYPE1_BIT] = st.trig_type[1];
            rd[TEC_FLAG1_BIT] = st.req_flag[1];
        end else if (idx == IDX_PRIO_LO_B) begin
            rd[BASE_W-1:0] = st.prio_lo_b;
        end else if (idx == IDX_PRIO_HI_B) begin
            rd[BASE_W-1:0] = st.prio_hi_b;
        end else if (idx == IDX_PRIO_LO_E) begin
            rd[EXT_W-1:0] = st.prio_lo_e;
        end else if (idx == IDX_PRIO_HI_E) begin
            rd[EXT_W-1:0] = st.prio_hi_e;
        end else if (idx == IDX_PRIO_LO_2) begin
            rd[EXT2_W-1:0] = st.prio_lo_2;
        end else if (idx == IDX_PRIO_HI_2) begin
            rd[EXT2_W-1:0] = st.prio_hi_2;
        end else if (idx == IDX_CTRL) begin
            rd[CTRL_GATE_BIT] = st.global_irq_gate;
        end else if (idx == IDX_SRC_EN) begin
            rd[NSRC-1:0] = st.src_en;
        end else if (idx == IDX_EVT_STAT) begin
            rd[NEXT-1:0] = st.evt_status;
        end else if (idx == IDX_EVT_EN) begin
            rd[NEXT-1:0] = st.evt_enable;
        end
        if (bus_hit && !st.ack) begin
            next_st.rdat = rd;
        end

        // Register writes, byte lane 0 for the narrow registers
        if (bus_wr && wb_sel_i[0]) begin
            if (idx == IDX_TMR_EXT) begin
                next_st.trig_type[0] = wb_dat_i[TEC_TYPE0_BIT];
                next_st.trig_type[1] = wb_dat_i[TEC_TYPE1_BIT];
            end else if (idx == IDX_PRIO_LO_B) begin
                next_st.prio_lo_b = wb_dat_i[BASE_W-1:0];
            end else if (idx == IDX_PRIO_HI_B) begin
                next_st.prio_hi_b = wb_dat_i[BASE_W-1:0];
            end else if (idx == IDX_PRIO_LO_E) begin
                next_st.prio_lo_e = wb_dat_i[EXT_W-1:0];
            end else if (idx == IDX_PRIO_HI_E) begin
                next_st.prio_hi_e = wb_dat_i[EXT_W-1:0];
            end else if (idx == IDX_PRIO_LO_2) begin
                next_st.prio_lo_2 = wb_dat_i[EXT2_W-1:0];
            end else if (idx == IDX_PRIO_HI_2) begin
                next_st.prio_hi_2 = wb_dat_i[EXT2_W-1:0];
            end else if (idx == IDX_CTRL) begin
                next_st.global_irq_gate = wb_dat_i[CTRL_GATE_BIT];
            end else if (idx == IDX_EVT_EN) begin
                next_st.evt_enable = wb_dat_i[NEXT-1:0];
            end
        end
        if (bus_wr && idx == IDX_SRC_EN) begin
            wv = lane_merge(32'(st.src_en), wb_dat_i, wb_sel_i);
            next_st.src_en = wv[NSRC-1:0];
        end

        // External flags; the type in force before a write decides the mode
        next_st.pin_prev = pins;
        for (int i = 0; i < NEXT; i++) begin
            if (st.trig_type[i] == TRIG_LEVEL) begin
                next_st.req_flag[i] = ~pins[i];
            end else begin
                // Set from an edge beats any clear in the same cycle
                if (wr_tec) begin
                    next_st.req_flag[i] = wb_dat_i[TEC_FLAG0_BIT + TEC_STRIDE * i];
                end else if (hw_clr[i]) begin
                    next_st.req_flag[i] = 1'b0;
                end
                if (fall[i]) begin
                    next_st.req_flag[i] = 1'b1;
                end
            end
        end

        // Sticky edge events; a new edge beats a clear write
        if (bus_wr && wb_sel_i[0] && idx == IDX_EVT_CLR) begin
            next_st.evt_status = st.evt_status & ~wb_dat_i[NEXT-1:0];
        end
        next_st.evt_status = next_st.evt_status | fall;

        // Registered selection toward the core
        next_st.req_valid = st.global_irq_gate & arb_any;
        next_st.req_src   = arb_idx;
        next_st.req_level = arb_lvl;
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register; pins idle high so reset sees no edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st          <= '0;
            st.pin_prev <= RST_PINS;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign wb_ack_o    = st.ack;
    assign wb_dat_o    = st.rdat;
    assign irq_req_o   = st.req_valid;
    assign irq_src_o   = st.req_src;
    assign irq_level_o = st.req_level;
    assign evt_irq_o   = |(st.evt_status & st.evt_enable);

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Bus handshake: one wait state, then a one-cycle ack
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_after_req: assert property (bus_hit && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing one cycle after request");

    // Priority writes land on the edge where ack is high
    a_lo_b_write: assert property (
        bus_wr && wb_sel_i[0] && idx == IDX_PRIO_LO_B
        |=> st.prio_lo_b == BASE_W'($past(wb_dat_i)))
        else $error("base low priority write lost");
    a_hi_e_write: assert property (
        bus_wr && wb_sel_i[0] && idx == IDX_PRIO_HI_E
        |=> st.prio_hi_e == EXT_W'($past(wb_dat_i)))
        else $error("extended high priority write lost");
    a_lo_2_write: assert property (
        bus_wr && wb_sel_i[0] && idx == IDX_PRIO_LO_2
        |=> st.prio_lo_2 == EXT2_W'($past(wb_dat_i)))
        else $error("second low priority write lost");

    // Type select: 0 picks level, 1 picks falling edge
    a_type_fall: assert property (
        wr_tec && wb_dat_i[TEC_TYPE1_BIT] |=> st.trig_type[1] == TRIG_FALL)
        else $error("type select 1 did not pick edge mode");
    a_type_level: assert property (
        wr_tec && !wb_dat_i[TEC_TYPE0_BIT] |=> st.trig_type[0] == TRIG_LEVEL)
        else $error("type select 0 did not pick level mode");

    // External request flags in both modes
    a_level_flag_pin: assert property (
        st.trig_type[0] == TRIG_LEVEL |=> st.req_flag[0] == !$past(ext_pin0_n_i))
        else $error("level flag does not mirror inverted pin");
    a_level_wr_ignored: assert property (
        st.trig_type[1] == TRIG_LEVEL && wr_tec && ext_pin1_n_i |=> !st.req_flag[1])
        else $error("software changed level mode flag");
    a_fall_sets_flag: assert property (
        st.trig_type[0] == TRIG_FALL && ext_pin0_n_i ##1
        !ext_pin0_n_i && st.trig_type[0] == TRIG_FALL |=> st.req_flag[0])
        else $error("falling edge did not set flag");
    a_edge_flag_holds: assert property (
        st.trig_type[1] == TRIG_FALL && st.req_flag[1] && !wr_tec && !hw_clr[1]
        |=> st.req_flag[1])
        else $error("edge flag dropped without a clear");
    a_svc_clears_flag: assert property (
        st.trig_type[0] == TRIG_FALL && hw_clr[0] && !wr_tec && !fall[0]
        |=> !st.req_flag[0])
        else $error("service entry did not clear edge flag");

    // Selection toward the core
    a_gate_blocks: assert property (
        !st.global_irq_gate |=> !irq_req_o)
        else $error("request passed a closed gate");
    a_gate_passes: assert property (
        st.global_irq_gate && arb_any |=> irq_req_o && irq_level_o == $past(arb_lvl))
        else $error("pending source not presented");
    a_level_join: assert property (
        arb_any |-> arb_lvl == {hi_vec[arb_idx], lo_vec[arb_idx]})
        else $error("winning level is not high bit joined with low bit");
    a_winner_pending: assert property (
        arb_any |-> req_vec[arb_idx])
        else $error("selected source has no pending request");

    // Event status; an enable write in the same cycle may mask the new event
    a_evt_on_fall: assert property (fall[0] |=> st.evt_status[0])
        else $error("falling edge not recorded as event");
    a_evt_sticky: assert property (
        st.evt_status[1] && !(bus_wr && wb_sel_i[0] && idx == IDX_EVT_CLR)
        |=> st.evt_status[1])
        else $error("event status dropped without a clear");
    a_evt_to_irq: assert property (
        fall[1] && st.evt_enable[1] && !(bus_wr && idx == IDX_EVT_EN) |=> evt_irq_o ##1 1'b1)
        else $error("enabled event did not raise interrupt");

    c_edge_flag: cover property (st.trig_type[0] == TRIG_FALL ##1 st.req_flag[0]);
    c_level_req: cover property (st.trig_type[1] == TRIG_LEVEL && st.req_flag[1]);
    c_top_level: cover property (irq_req_o && irq_level_o == 2'h3);
    c_bus_write: cover property (bus_wr && idx == IDX_PRIO_HI_E);
    c_svc_clear: cover property (hw_clr[1] && st.req_flag[1]);

endmodule

// File: bench/ips_partner.sv
// Far-side model: requesting peripherals and a core that services requests
`timescale 1ns/1ps
module ips_partner
    import ips_pkg::*;
(
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             irq_req_i,
    input  wire logic [SRC_W-1:0] irq_src_i,
    input  wire logic [NSRC-1:0]  raise_i,
    input  wire logic             auto_i,
    output logic      [NSRC-1:0]  periph_req_o,
    output logic                  svc_ack_o,
    output logic      [SRC_W-1:0] svc_src_o
);
    logic [1:0] cool;

    ////////////////////////////////////////////////////////////////////////////
    // Requests stay up until serviced; cooldown lets the registered request fall
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            periph_req_o <= '0;
            svc_ack_o    <= 1'b0;
            svc_src_o    <= '0;
            cool         <= 2'h0;
        end else begin
            svc_ack_o    <= 1'b0;
            periph_req_o <= periph_req_o | raise_i;
            if (cool != 2'h0) begin
                cool <= cool - 2'h1;
            end else if (auto_i && irq_req_i) begin
                svc_ack_o               <= 1'b1; // Service entry clears edge flag
                svc_src_o               <= irq_src_i;
                periph_req_o[irq_src_i] <= 1'b0;
                cool                    <= 2'h3;
            end
        end
    end
endmodule

// File: bench/int_priority_extint_ctrl_test.sv
// Self-checking bench for the priority and external trigger block
`timescale 1ns/1ps
module int_priority_extint_ctrl_test
    import ips_pkg::*;
;
    logic             clk_i = 1'b0;
    logic             rst_i = 1'b1;
    logic             cyc   = 1'b0;
    logic             stb   = 1'b0;
    logic             we    = 1'b0;
    logic [9:0]       adr   = '0;
    logic [3:0]       sel   = '0;
    logic [31:0]      wdat  = '0;
    logic [31:0]      rdat;
    logic             pin0  = 1'b1;
    logic             pin1  = 1'b1;
    logic             auto_svc = 1'b0;
    logic [NSRC-1:0]  raise = '0;
    logic [31:0]      wb_dat;
    logic             ack, irq_req, evt_irq, svc_ack;
    logic [SRC_W-1:0] irq_src, svc_src;
    logic [1:0]       irq_lvl;
    logic [NSRC-1:0]  preq;
    int               failures = 0;
    int               n_compared = 0;
    logic [7:0] ridx [7] = '{IDX_TMR_EXT, IDX_PRIO_HI_B, IDX_PRIO_LO_B, IDX_PRIO_LO_E,
                             IDX_PRIO_HI_E, IDX_PRIO_LO_2, IDX_PRIO_HI_2};
    // Control keeps only types: flag writes ignored in level mode
    logic [7:0] rmask [7] = '{8'h05, 8'h7F, 8'h7F, 8'hFF, 8'hFF, 8'h07, 8'h07};
    logic [7:0] pidx [5] = '{IDX_CTRL, IDX_PRIO_LO_E, IDX_PRIO_HI_2, IDX_PRIO_HI_B,
                             IDX_PRIO_LO_B};
    logic [7:0] pdat [5] = '{8'h01, 8'h08, 8'h04, 8'h08, 8'h08};
    logic [4:0] psrc [5] = '{5'h03, 5'h0A, 5'h11, 5'h03, 5'h03};
    logic [1:0] plvl [5] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h3};

    ips_ctrl u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat),
        .wb_ack_o(ack), .ext_pin0_n_i(pin0), .ext_pin1_n_i(pin1), .periph_req_i(preq),
        .svc_ack_i(svc_ack), .svc_src_i(svc_src), .irq_req_o(irq_req),
        .irq_src_o(irq_src), .irq_level_o(irq_lvl), .evt_irq_o(evt_irq)
    );

    ips_partner u_partner (
        .clk_i(clk_i), .rst_i(rst_i), .irq_req_i(irq_req), .irq_src_i(irq_src),
        .raise_i(raise), .auto_i(auto_svc), .periph_req_o(preq),
        .svc_ack_o(svc_ack), .svc_src_o(svc_src)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Clock and watchdog
    initial begin
        forever #25 clk_i = ~clk_i;
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        failures++;
        tally_and_finish();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Classic cycle; waits for ack with no assumed latency
    task automatic xfer(input logic [7:0] idx, input logic w, input logic [31:0] d);
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= {idx, 2'b00};
        sel  <= 4'hF;
        wdat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        rdat = wb_dat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask

    task automatic rd_chk(input string what, input logic [7:0] idx, input logic [31:0] exp);
        xfer(idx, 1'b0, 32'h0);
        chk(what, rdat, exp);
    endtask

    task automatic tally_and_finish();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (int i = 0; i < 7; i++) begin
            rd_chk("reset value", ridx[i], 32'h0);
            xfer(ridx[i], 1'b1, 32'hFF);
            rd_chk("writable bits", ridx[i], {24'h0, rmask[i]});
            xfer(ridx[i], 1'b1, 32'h0);
        end
        xfer(8'h10, 1'b1, 32'hFF);
        rd_chk("unmapped", 8'h10, 32'h0);
        // Level mode: flags follow the inverted pins
        pin0 <= 1'b0;
        pin1 <= 1'b0;
        repeat (3) @(posedge clk_i);
        rd_chk("level flags", IDX_TMR_EXT, 32'h0A);
        xfer(IDX_TMR_EXT, 1'b1, 32'h0);
        rd_chk("level flags kept", IDX_TMR_EXT, 32'h0A);
        rd_chk("event status", IDX_EVT_STAT, 32'h3);
        chk("event irq masked", evt_irq, 32'h0);
        // Both enables on, so the later input 1 edge also reaches the event interrupt
        xfer(IDX_EVT_EN, 1'b1, 32'h3);
        @(posedge clk_i);
        chk("event irq", evt_irq, 32'h1);
        xfer(IDX_EVT_CLR, 1'b1, 32'h3);
        @(posedge clk_i);
        chk("event irq cleared", evt_irq, 32'h0);
        pin0 <= 1'b1;
        pin1 <= 1'b1;
        repeat (3) @(posedge clk_i);
        rd_chk("level released", IDX_TMR_EXT, 32'h0);
        // Edge mode: sticky flags, software set and clear
        xfer(IDX_TMR_EXT, 1'b1, 32'h05);
        rd_chk("edge types", IDX_TMR_EXT, 32'h05);
        xfer(IDX_TMR_EXT, 1'b1, 32'h0F);
        rd_chk("edge flag set", IDX_TMR_EXT, 32'h0F);
        xfer(IDX_TMR_EXT, 1'b1, 32'h05);
        pin0 <= 1'b0;
        @(posedge clk_i);
        pin0 <= 1'b1;
        repeat (3) @(posedge clk_i);
        rd_chk("edge sticky", IDX_TMR_EXT, 32'h07);
        xfer(IDX_TMR_EXT, 1'b1, 32'h05);
        rd_chk("edge sw clear", IDX_TMR_EXT, 32'h05);
        // Service entry clears the edge flag of input 1
        xfer(IDX_SRC_EN, 1'b1, 32'h4);
        xfer(IDX_CTRL, 1'b1, 32'h1);
        auto_svc <= 1'b1;
        pin1 <= 1'b0;
        @(posedge clk_i);
        pin1 <= 1'b1;
        repeat (12) @(posedge clk_i);
        rd_chk("service clear", IDX_TMR_EXT, 32'h05);
        chk("serviced source", svc_src, {27'h0, SRC_EXT1});
        auto_svc <= 1'b0;
        // Priority table: level join and tie break
        xfer(IDX_SRC_EN, 1'b1, 32'h3FFFF);
        raise <= 18'h20408;
        @(posedge clk_i);
        raise <= '0;
        for (int i = 0; i < 5; i++) begin
            xfer(pidx[i], 1'b1, {24'h0, pdat[i]});
            repeat (3) @(posedge clk_i);
            chk("request", irq_req, 32'h1);
            chk("winner", irq_src, {27'h0, psrc[i]});
            chk("level", irq_lvl, {30'h0, plvl[i]});
        end
        xfer(IDX_CTRL, 1'b1, 32'h0);
        repeat (3) @(posedge clk_i);
        chk("gated", irq_req, 32'h0);
        xfer(IDX_CTRL, 1'b1, 32'h1);
        auto_svc <= 1'b1;
        repeat (30) @(posedge clk_i);
        chk("drained", {14'h0, preq}, 32'h0);
        chk("idle", irq_req, 32'h0);
        tally_and_finish();
    end
endmodule
